// ===== rtl/owd_pkg.sv
// constants and types for the option word and instruction decode core
package owd_pkg;
	localparam logic [12:0] CFG_RESET = 13'h1fff;
	localparam logic [12:0] CUST_RESET = 13'h0000;
	localparam logic [11:0] A_CFG = 12'h000;
	localparam logic [11:0] A_INSTR = 12'h004;
	localparam logic [11:0] A_STAT = 12'h008;
	localparam logic [11:0] A_ACC = 12'h00c;
	localparam logic [11:0] A_PC = 12'h010;
	localparam logic [11:0] A_DEC = 12'h014;
	localparam logic [11:0] A_CUST = 12'h018;
	localparam logic [3:0] A_RFILE_PAGE = 4'h1;
	localparam logic [12:0] OP_NOP = 13'h0000;
	localparam logic [12:0] OP_DAA = 13'h0001;
	localparam logic [12:0] OP_CONTW = 13'h0002;
	localparam logic [12:0] OP_SLEEP = 13'h0003;
	localparam logic [12:0] OP_WATCHDOG_CLEAR_OP = 13'h0004;
	localparam logic [12:0] OP_ENI = 13'h0010;
	localparam logic [12:0] OP_DISI = 13'h0011;
	localparam logic [12:0] OP_RET = 13'h0012;
	localparam logic [12:0] OP_INTERRUPT_RETURN_OP = 13'h0013;
	localparam logic [12:0] OP_CONTR = 13'h0014;
	localparam logic [8:0] GRP_IOW = 9'h000;
	localparam logic [8:0] GRP_IOR = 9'h001;
	localparam logic [5:0] PC_REG = 6'h02;
	localparam logic [3:0] CYC_TWO = 4'h2;
	localparam logic [3:0] CYC_FOUR = 4'h4;
	localparam logic [3:0] DAA_LIMIT = 4'h9;
	localparam logic [8:0] DAA_LOW = 9'h006;
	localparam logic [8:0] DAA_HIGH = 9'h060;
	localparam int ST_Z = 0;
	localparam int ST_C = 1;
	localparam int ST_DC = 2;
	localparam int ST_P = 3;
	localparam int ST_T = 4;
	localparam int ST_IE = 5;
	localparam int ST_BUSY = 6;
	localparam int ST_SLEEP = 7;
	localparam int ST_SKIP = 8;
	localparam int ST_OVR = 9;
	localparam int ST_ILL = 10;
	localparam int ST_WTO = 11;
	localparam int PC_TOS_LSB = 16;

	typedef enum logic [1:0]
	{
		OWD_IDLE = 2'b00,
		OWD_EXEC = 2'b01,
		OWD_SLEEP = 2'b10
	} owd_phase_t;

	typedef enum logic [3:0]
	{
		CL_MOVW = 4'h0, CL_CLR = 4'h1, CL_SUB = 4'h2, CL_DEC = 4'h3,
		CL_OR = 4'h4, CL_AND = 4'h5, CL_XOR = 4'h6, CL_ADD = 4'h7,
		CL_MOV = 4'h8, CL_COM = 4'h9, CL_INC = 4'ha, CL_DJZ = 4'hb,
		CL_RRC = 4'hc, CL_RLC = 4'hd, CL_SWAP = 4'he, CL_JZ = 4'hf
	} owd_cls_t;

	// option word layout, top bit first
	typedef struct packed {
		logic osc_type_select;
		logic watchdog_enable_n;
		logic cycle_clock_count;
		logic code_protect_n;
		logic crystal_freq_range;
		logic rc_style_select;
		logic power_level_select;
		logic [5:0] customer_id;
	} owd_cfg_t;

	typedef struct packed {
		logic act;
		logic wr;
		logic [11:0] addr;
	} owd_req_t;
endpackage

// ===== rtl/owd_core.sv
// option word decode and instruction execute core with an ahb-lite register slave
`timescale 1ns/1ps
module owd_core #(
	parameter logic [15:0] WDT_LIMIT = 16'hffff
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output owd_pkg::owd_cfg_t cfg_out,
	output logic sleeping,
	output logic [7:0] port5,
	output logic [7:0] port6
);
	typedef struct packed {
		owd_pkg::owd_phase_t ph;
		logic [3:0] cnt;
		logic skip;
		owd_pkg::owd_cfg_t cfg;
		logic [12:0] cust;
		logic [12:0] last;
		logic [7:0] a;
		logic z;
		logic c;
		logic dc;
		logic t;
		logic p;
		logic ie;
		logic [9:0] pc;
		logic [9:0] tos;
		logic [7:0] cont;
		logic [63:0][7:0] rf;
		logic [15:0][7:0] ioc;
		logic [15:0] wdt;
		logic ovr;
		logic ill;
		logic wto;
		owd_pkg::owd_req_t req;
		logic [31:0] rdata;
		logic rdy;
		logic resp;
		logic slp;
	} owd_st_t;

	owd_st_t s;
	owd_st_t n;
	logic [12:0] ins;
	logic [5:0] rsel;
	logic [2:0] bsel;
	logic [7:0] rd;
	owd_pkg::owd_cls_t cls;
	logic dir;
	logic [7:0] res;
	logic wr_r;
	logic wr_a;
	logic pcw;
	logic go;
	logic wr_instr;
	logic [8:0] wide;
	logic [3:0] cpc;
	logic [11:0] raddr;

	assign ins = hwdata[12:0];
	assign rsel = ins[5:0];
	assign bsel = ins[8:6];
	assign cls = owd_pkg::owd_cls_t'(ins[10:7]);
	assign dir = ins[6];
	assign raddr = haddr[11:0];
	// register 2 is the low byte of the program counter
	assign rd = (rsel == owd_pkg::PC_REG) ? s.pc[7:0] : s.rf[rsel];
	assign wr_instr = s.req.act && s.req.wr && s.req.addr == owd_pkg::A_INSTR;
	assign go = wr_instr && s.ph == owd_pkg::OWD_IDLE;
	assign cpc = s.cfg.cycle_clock_count ? owd_pkg::CYC_FOUR : owd_pkg::CYC_TWO;

	always_comb
	begin
		n = s;
		res = 8'h00;
		wr_r = 1'b0;
		wr_a = 1'b0;
		pcw = 1'b0;
		wide = 9'h000;
		n.rdy = 1'b1;
		n.resp = 1'b0;
		// read data is sampled at the address phase, so a read right after
		// a write to the same word returns the value from before that write
		n.req.act = hsel && htrans[1] && hready;
		n.req.wr = hwrite;
		n.req.addr = raddr;
		n.rdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			case (raddr)
				owd_pkg::A_CFG: n.rdata[12:0] = s.cfg;
				owd_pkg::A_CUST: n.rdata[12:0] = s.cust;
				owd_pkg::A_INSTR: n.rdata[12:0] = s.last;
				owd_pkg::A_ACC: n.rdata[7:0] = s.a;
				owd_pkg::A_PC: n.rdata = {6'h00, s.tos, 6'h00, s.pc};
				// branch literal in the low ten bits, short literal from bit 16
				owd_pkg::A_DEC: n.rdata = {8'h00, s.last[7:0], 6'h00, s.last[9:0]};
				owd_pkg::A_STAT:
				begin
					n.rdata[owd_pkg::ST_Z] = s.z;
					n.rdata[owd_pkg::ST_C] = s.c;
					n.rdata[owd_pkg::ST_DC] = s.dc;
					n.rdata[owd_pkg::ST_P] = s.p;
					n.rdata[owd_pkg::ST_T] = s.t;
					n.rdata[owd_pkg::ST_IE] = s.ie;
					n.rdata[owd_pkg::ST_BUSY] = s.ph == owd_pkg::OWD_EXEC;
					n.rdata[owd_pkg::ST_SLEEP] = s.ph == owd_pkg::OWD_SLEEP;
					n.rdata[owd_pkg::ST_SKIP] = s.skip;
					n.rdata[owd_pkg::ST_OVR] = s.ovr;
					n.rdata[owd_pkg::ST_ILL] = s.ill;
					n.rdata[owd_pkg::ST_WTO] = s.wto;
				end
				default:
				begin
					if (raddr[11:8] == owd_pkg::A_RFILE_PAGE)
						n.rdata[7:0] = (raddr[7:2] == owd_pkg::PC_REG) ? s.pc[7:0]
							: s.rf[raddr[7:2]];
				end
			endcase
		end
		// bus writes first, so hardware events below win over clears
		if (s.req.act && s.req.wr)
		begin
			case (s.req.addr)
				owd_pkg::A_CFG: n.cfg = owd_pkg::owd_cfg_t'(hwdata[12:0]);
				owd_pkg::A_CUST: n.cust = hwdata[12:0];
				owd_pkg::A_ACC: n.a = hwdata[7:0];
				owd_pkg::A_PC:
				begin
					n.pc = hwdata[9:0];
					n.tos = hwdata[owd_pkg::PC_TOS_LSB +: 10];
				end
				owd_pkg::A_STAT:
				begin
					if (hwdata[owd_pkg::ST_OVR])
						n.ovr = 1'b0;
					if (hwdata[owd_pkg::ST_ILL])
						n.ill = 1'b0;
					if (hwdata[owd_pkg::ST_WTO])
						n.wto = 1'b0;
				end
				default:
				begin
					if (s.req.addr[11:8] == owd_pkg::A_RFILE_PAGE)
					begin
						if (s.req.addr[7:2] == owd_pkg::PC_REG)
							n.pc[7:0] = hwdata[7:0];
						else
							n.rf[s.req.addr[7:2]] = hwdata[7:0];
					end
				end
			endcase
		end
		// watchdog runs while its enable bit is low
		if (!s.cfg.watchdog_enable_n)
		begin
			if (s.wdt == WDT_LIMIT)
			begin
				n.wdt = 16'h0000;
				n.t = 1'b0;
				n.wto = 1'b1;
				if (s.ph == owd_pkg::OWD_SLEEP)
					n.ph = owd_pkg::OWD_IDLE;
			end
			else
				n.wdt = s.wdt + 16'h0001;
		end
		if (s.ph == owd_pkg::OWD_EXEC)
		begin
			if (s.cnt == 4'h1)
				n.ph = owd_pkg::OWD_IDLE;
			n.cnt = s.cnt - 4'h1;
		end
		// a word arriving mid-instruction is dropped; one arriving in sleep wakes
		if (wr_instr && s.ph == owd_pkg::OWD_EXEC)
			n.ovr = 1'b1;
		if (wr_instr && s.ph == owd_pkg::OWD_SLEEP)
			n.ph = owd_pkg::OWD_IDLE;
		if (go)
		begin
			n.last = ins;
			n.skip = 1'b0;
			n.pc = s.pc + 10'h001;
			if (s.skip)
				n.last = owd_pkg::OP_NOP;
			else if (ins == owd_pkg::OP_NOP)
				n.last = ins;
			else if (ins == owd_pkg::OP_DAA)
			begin
				wide = {1'b0, s.a};
				if (s.a[3:0] > owd_pkg::DAA_LIMIT || s.dc)
					wide = wide + owd_pkg::DAA_LOW;
				if (wide[7:4] > owd_pkg::DAA_LIMIT || s.c || wide[8])
					wide = wide + owd_pkg::DAA_HIGH;
				n.a = wide[7:0];
				n.c = wide[8] | s.c;
			end
			else if (ins == owd_pkg::OP_CONTW)
				n.cont = s.a;
			else if (ins == owd_pkg::OP_SLEEP || ins == owd_pkg::OP_WATCHDOG_CLEAR_OP)
			begin
				n.wdt = 16'h0000;
				n.t = 1'b1;
				n.p = ins == owd_pkg::OP_WATCHDOG_CLEAR_OP;
			end
			else if (ins[12:4] == owd_pkg::GRP_IOW)
				n.ioc[ins[3:0]] = s.a;
			else if (ins == owd_pkg::OP_ENI || ins == owd_pkg::OP_DISI)
				n.ie = ins == owd_pkg::OP_ENI;
			else if (ins == owd_pkg::OP_RET || ins == owd_pkg::OP_INTERRUPT_RETURN_OP)
			begin
				n.pc = s.tos;
				if (ins == owd_pkg::OP_INTERRUPT_RETURN_OP)
					n.ie = 1'b1;
			end
			else if (ins == owd_pkg::OP_CONTR)
				n.a = s.cont;
			else if (ins[12:4] == owd_pkg::GRP_IOR)
				n.a = s.ioc[ins[3:0]];
			else if (ins[12:11] == 2'b00)
			begin
				wr_r = dir;
				wr_a = !dir;
				case (cls)
					owd_pkg::CL_MOVW:
					begin
						res = s.a;
						wr_a = 1'b0;
						if (!dir)
							n.ill = 1'b1;
					end
					owd_pkg::CL_CLR: res = 8'h00;
					owd_pkg::CL_SUB:
					begin
						wide = {1'b0, rd} - {1'b0, s.a};
						res = wide[7:0];
						n.c = !wide[8];
						n.dc = rd[3:0] >= s.a[3:0];
					end
					owd_pkg::CL_ADD:
					begin
						wide = {1'b0, rd} + {1'b0, s.a};
						res = wide[7:0];
						n.c = wide[8];
						n.dc = ({1'b0, rd[3:0]} + {1'b0, s.a[3:0]}) > 5'h0f;
					end
					owd_pkg::CL_DEC, owd_pkg::CL_DJZ: res = rd - 8'h01;
					owd_pkg::CL_INC, owd_pkg::CL_JZ: res = rd + 8'h01;
					owd_pkg::CL_OR: res = s.a | rd;
					owd_pkg::CL_AND: res = s.a & rd;
					owd_pkg::CL_XOR: res = s.a ^ rd;
					owd_pkg::CL_COM: res = ~rd;
					owd_pkg::CL_MOV: res = rd;
					owd_pkg::CL_RRC:
					begin
						res = {s.c, rd[7:1]};
						n.c = rd[0];
					end
					owd_pkg::CL_RLC:
					begin
						res = {rd[6:0], s.c};
						n.c = rd[7];
					end
					owd_pkg::CL_SWAP: res = {rd[3:0], rd[7:4]};
					default: res = rd;
				endcase
				if (cls == owd_pkg::CL_DJZ || cls == owd_pkg::CL_JZ)
					n.skip = res == 8'h00;
				else if (cls != owd_pkg::CL_RRC && cls != owd_pkg::CL_RLC
					&& cls != owd_pkg::CL_SWAP && !(cls == owd_pkg::CL_MOVW))
					n.z = res == 8'h00;
			end
			else if (ins[12:11] == 2'b01)
			begin
				case (ins[10:9])
					2'b00:
					begin
						res = rd & ~(8'h01 << bsel);
						wr_r = 1'b1;
					end
					2'b01:
					begin
						res = rd | (8'h01 << bsel);
						wr_r = 1'b1;
					end
					2'b10: n.skip = !rd[bsel];
					default: n.ill = 1'b1;
				endcase
			end
			else
				n.ill = 1'b1;
			if (wr_a)
				n.a = res;
			if (wr_r && rsel == owd_pkg::PC_REG)
			begin
				n.pc = {s.pc[9:8], res};
				pcw = 1'b1;
			end
			else if (wr_r)
				n.rf[rsel] = res;
			n.cnt = (pcw ? {cpc[2:0], 1'b0} : cpc) - 4'h1;
			n.ph = owd_pkg::OWD_EXEC;
			if (!s.skip && ins == owd_pkg::OP_SLEEP)
				n.ph = owd_pkg::OWD_SLEEP;
		end
		n.slp = n.ph == owd_pkg::OWD_SLEEP;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.cfg <= owd_pkg::CFG_RESET;
			s.cust <= owd_pkg::CUST_RESET;
			s.t <= 1'b1;
			s.p <= 1'b1;
			s.rdy <= 1'b1;
		end
		else
			s <= n;
	end

	assign hrdata = s.rdata;
	assign hreadyout = s.rdy;
	assign hresp = s.resp;
	assign cfg_out = s.cfg;
	assign sleeping = s.slp;
	assign port5 = s.rf[5];
	assign port6 = s.rf[6];

	logic busy;
	logic plain;
	assign busy = s.ph == owd_pkg::OWD_EXEC;
	assign plain = go && !s.skip && ins[12:11] == 2'b00 && !dir && cls != owd_pkg::CL_MOVW;

	sequence one_more_s;
		busy ##1 !busy;
	endsequence
	sequence seven_more_s;
		busy [*7] ##1 !busy;
	endsequence

	cfg_take_a: assert property (@(posedge clock) disable iff (rst)
		s.req.act && s.req.wr && s.req.addr == owd_pkg::A_CFG
		|=> cfg_out == $past(hwdata[12:0]))
		else $error("option word not taken");
	wdt_hold_a: assert property (@(posedge clock) disable iff (rst)
		s.cfg.watchdog_enable_n && !go && $past(!go) |=> s.wdt == $past(s.wdt))
		else $error("watchdog moved while disabled");
	short_cycle_a: assert property (@(posedge clock) disable iff (rst)
		plain && !s.cfg.cycle_clock_count |=> one_more_s)
		else $error("two clock instruction length wrong");
	pc_write_a: assert property (@(posedge clock) disable iff (rst)
		go && !s.skip && ins[12:11] == 2'b00 && dir && rsel == owd_pkg::PC_REG
		&& s.cfg.cycle_clock_count |=> seven_more_s)
		else $error("pc write length wrong");
	wdt_clear_a: assert property (@(posedge clock) disable iff (rst)
		go && !s.skip && ins == owd_pkg::OP_WATCHDOG_CLEAR_OP |=> s.t && s.p && s.wdt == 16'h0000 && busy)
		else $error("watchdog clear wrong");
	sleep_op_a: assert property (@(posedge clock) disable iff (rst)
		go && !s.skip && ins == owd_pkg::OP_SLEEP |=> sleeping && !s.p && s.t)
		else $error("sleep entry wrong");
	int_return_a: assert property (@(posedge clock) disable iff (rst)
		go && !s.skip && ins == owd_pkg::OP_INTERRUPT_RETURN_OP |=> s.pc == $past(s.tos) && s.ie)
		else $error("interrupt return wrong");
	rotate_left_a: assert property (@(posedge clock) disable iff (rst)
		plain && cls == owd_pkg::CL_RLC |=> s.c == $past(rd[7]) && s.a[0] == $past(s.c))
		else $error("rotate left wrong");
	swap_a: assert property (@(posedge clock) disable iff (rst)
		plain && cls == owd_pkg::CL_SWAP
		|=> s.a == {$past(rd[3:0]), $past(rd[7:4])} && $stable(s.z) && $stable(s.c))
		else $error("nibble swap wrong");
	skip_zero_a: assert property (@(posedge clock) disable iff (rst)
		plain && cls == owd_pkg::CL_DJZ && rd == 8'h01 |=> s.skip && $stable(s.z))
		else $error("decrement skip wrong");
	logic_flags_a: assert property (@(posedge clock) disable iff (rst)
		plain && (cls == owd_pkg::CL_AND || cls == owd_pkg::CL_XOR)
		|=> $stable(s.c) && $stable(s.dc))
		else $error("logic op touched carry");
endmodule

// ===== verification/owd_prog_mem.sv
// program memory model supplying instruction words to the bench
`timescale 1ns/1ps
module owd_prog_mem (
	input wire logic [2:0] addr,
	output logic [12:0] word
);
	// short directed program; empty slots hold no-operation
	always_comb
	begin
		case (addr)
			3'h0: word = owd_pkg::OP_WATCHDOG_CLEAR_OP;
			3'h1: word = owd_pkg::OP_SLEEP;
			3'h2: word = owd_pkg::OP_INTERRUPT_RETURN_OP;
			3'h3: word = 13'h0042;
			default: word = owd_pkg::OP_NOP;
		endcase
	end
endmodule

// ===== verification/owd_core_tb_top.sv
// self-checking bench for the option word and instruction decode core
`timescale 1ns/1ps
module owd_core_tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	owd_pkg::owd_cfg_t cfg_out;
	logic sleeping;
	logic [7:0] port5;
	logic [7:0] port6;
	logic [2:0] pm_addr = 3'h0;
	logic [12:0] pm_word;
	logic [31:0] rd;
	integer seed = 32'h429f;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	int ma = 0;
	int mz = 0;
	int mc = 0;
	int mdc = 0;
	int mskip = 0;
	int rf[64];
	assign hready = hreadyout;
	always #5 clock = ~clock;
	owd_core #(.WDT_LIMIT(16'h0010)) dut_u (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cfg_out(cfg_out), .sleeping(sleeping), .port5(port5), .port6(port6));
	owd_prog_mem pm_u (.addr(pm_addr), .word(pm_word));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hready and read data are taken as they stand just before the edge
	task automatic phase_end();
		logic ok;
		ok = 1'b0;
		while (!ok)
		begin
			@(negedge clock);
			ok = hreadyout === 1'b1;
			rd = hrdata;
			@(posedge clock);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, a};
		phase_end();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		phase_end();
	endtask
	function automatic logic [11:0] raddr(input int r);
		return {owd_pkg::A_RFILE_PAGE, 6'(r), 2'h0};
	endfunction
	function automatic void mexec(input logic [12:0] w);
		int r;
		int v;
		int b;
		int res;
		r = w[5:0];
		v = rf[r];
		b = w[8:6];
		if (mskip)
		begin
			mskip = 0;
			return;
		end
		case (w[11:9])
			3'h4: rf[r] = v & ~(1 << b);
			3'h5: rf[r] = v | (1 << b);
			3'h6: mskip = ((v >> b) & 1) == 0;
			default: ;
		endcase
		if (w[11])
			return;
		case (w[11:7])
			5'h02:
			begin
				res = (v - ma) & 8'hff;
				mc = v >= ma;
				mdc = (v & 4'hf) >= (ma & 4'hf);
			end
			5'h03: res = (v - 1) & 8'hff;
			5'h04: res = v | ma;
			5'h05: res = v & ma;
			5'h06: res = v ^ ma;
			5'h07:
			begin
				res = v + ma;
				mc = res > 8'hff;
				mdc = (v & 4'hf) + (ma & 4'hf) > 4'hf;
				res = res & 8'hff;
			end
			5'h08: res = v;
			5'h09: res = ~v & 8'hff;
			5'h0a: res = (v + 1) & 8'hff;
			5'h0b: res = (v - 1) & 8'hff;
			5'h0c:
			begin
				res = (mc << 7) | (v >> 1);
				mc = v & 1;
			end
			5'h0d:
			begin
				res = ((v << 1) & 8'hfe) | mc;
				mc = v >> 7;
			end
			5'h0e: res = ((v << 4) & 8'hf0) | (v >> 4);
			5'h0f: res = (v + 1) & 8'hff;
			default: return;
		endcase
		if (w[11:7] < 5'h0b)
			mz = res == 0;
		if (w[11:7] == 5'h0b || w[11:7] == 5'h0f)
			mskip = res == 0;
		if (w[6])
			rf[r] = res;
		else
			ma = res;
	endfunction
	// issue a word and poll until the core is no longer busy
	task automatic exec(input logic [12:0] w, output int n);
		bus(1'b1, owd_pkg::A_INSTR, {19'h0, w});
		mexec(w);
		n = 0;
		do
		begin
			bus(1'b0, owd_pkg::A_STAT, 32'h0);
			n++;
		end
		while (rd[owd_pkg::ST_BUSY] === 1'b1);
	endtask
	task automatic fetch(input logic [2:0] a);
		pm_addr <= a;
		@(posedge clock);
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fails++;
			results();
		end
	end
	initial
	begin
		int n;
		int n2;
		int n2p;
		int n4p;
		int r;
		int v;
		logic [12:0] w;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		bus(1'b0, owd_pkg::A_CFG, 32'h0);
		chk(rd, 32'h1fff);
		bus(1'b0, owd_pkg::A_STAT, 32'h0);
		chk(rd & 32'h18, 32'h18);
		repeat (4)
		begin
			w = 13'($random(seed)) | 13'h0800;
			bus(1'b1, owd_pkg::A_CFG, {19'h0, w});
			bus(1'b0, owd_pkg::A_CFG, 32'h0);
			chk(rd, {19'h0, w});
			// output is looked at only once it has settled, not at its launch edge
			chk({19'h0, cfg_out}, {19'h0, w});
		end
		bus(1'b1, owd_pkg::A_CUST, 32'h0abc);
		bus(1'b0, owd_pkg::A_CUST, 32'h0);
		chk(rd, 32'h0abc);
		bus(1'b0, owd_pkg::A_CFG, 32'h0);
		chk(rd, {19'h0, w});
		bus(1'b0, 12'h01c, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, owd_pkg::A_CFG, 32'h1800);
		for (int p = 6'h04; p <= 6'h37; p++)
			for (int i = 0; i < 3; i++)
			begin
				r = 8'h10 + (($random(seed) & 8'hff) % 8'h30);
				v = (i == 0) ? 1 : (i == 1) ? 8'hff : ($random(seed) & 8'hff);
				ma = $random(seed) & 8'hff;
				rf[r] = v;
				bus(1'b1, owd_pkg::A_ACC, ma);
				bus(1'b1, raddr(r), v);
				w = {1'b0, 6'(p), 6'(r)};
				exec(w, n);
				bus(1'b0, owd_pkg::A_ACC, 32'h0);
				chk(rd, ma);
				bus(1'b0, raddr(r), 32'h0);
				chk(rd, rf[r]);
				bus(1'b0, owd_pkg::A_STAT, 32'h0);
				chk(rd & 32'h107, 32'((mskip << 8) | (mdc << 2) | (mc << 1) | mz));
				bus(1'b0, owd_pkg::A_INSTR, 32'h0);
				chk(rd, {19'h0, w});
				bus(1'b0, owd_pkg::A_DEC, 32'h0);
				chk(rd, {8'h00, w[7:0], 6'h00, w[9:0]});
				if (mskip)
				begin
					exec(13'h0510, n);
					bus(1'b0, owd_pkg::A_ACC, 32'h0);
					chk(rd, ma);
				end
			end
		exec(owd_pkg::OP_NOP, n2);
		fetch(3'h3);
		exec(pm_word, n2p);
		chk(n2p > n2, 32'h1);
		bus(1'b1, owd_pkg::A_CFG, 32'h1c00);
		fetch(3'h3);
		exec(pm_word, n4p);
		chk(n4p > n2p, 32'h1);
		bus(1'b1, owd_pkg::A_CFG, 32'h1000);
		do
			bus(1'b0, owd_pkg::A_STAT, 32'h0);
		while (rd[owd_pkg::ST_WTO] !== 1'b1);
		chk(rd & 32'h810, 32'h800);
		fetch(3'h0);
		exec(pm_word, n);
		chk(rd & 32'h18, 32'h18);
		bus(1'b1, owd_pkg::A_CFG, 32'h1800);
		bus(1'b1, owd_pkg::A_STAT, 32'h800);
		fetch(3'h1);
		exec(pm_word, n);
		chk(rd & 32'h98, 32'h90);
		chk(sleeping, 32'h1);
		bus(1'b1, owd_pkg::A_INSTR, 32'h0);
		bus(1'b0, owd_pkg::A_STAT, 32'h0);
		chk(sleeping, 32'h0);
		bus(1'b1, owd_pkg::A_PC, 32'h0155_0000);
		fetch(3'h2);
		exec(pm_word, n);
		chk(rd & 32'h20, 32'h20);
		bus(1'b0, owd_pkg::A_PC, 32'h0);
		chk(rd & 32'h3ff, 32'h155);
		v = $random(seed) & 8'hff;
		bus(1'b1, raddr(5), v);
		bus(1'b0, raddr(5), 32'h0);
		chk(rd, v);
		chk(port5, v);
		rf[6] = 8'h7f;
		bus(1'b1, raddr(6), 32'h7f);
		exec(13'h0546, n);
		chk(port6, rf[6]);
		// unused bit-test form is flagged illegal and runs as a no-op
		exec(13'h0e00, n);
		chk(rd & 32'h400, 32'h400);
		// four clocks keep the core busy long enough for a second word to collide
		bus(1'b1, owd_pkg::A_CFG, 32'h1c00);
		bus(1'b1, owd_pkg::A_INSTR, 32'h0);
		exec(owd_pkg::OP_NOP, n);
		chk(rd & 32'h200, 32'h200);
		results();
	end
endmodule
